// [src/i2c_status_defines.vh]
`ifndef I2C_STATUS_DEFINES_VH
`define I2C_STATUS_DEFINES_VH

// Register offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h01
`define OFS_MODE 8'h02
`define OFS_OWN_ADDR 8'h03
`define OFS_SECOND_ADDR 8'h04
`define OFS_DATA 8'h05

// Control register fields
`define CTRL_EN 7
`define CTRL_MASTER 6
`define CTRL_DIR 5
`define CTRL_ACK_CHECK 4
`define CTRL_BUS_OCC 3
`define CTRL_IRQ 2
`define CTRL_COND_ISSUE 1
`define CTRL_PAUSE 0

// Status register fields
`define ST_EARLY_END 7
`define ST_NORMAL_END 6
`define ST_CONT_XFER 5
`define ST_SECOND_HIT 4
`define ST_ARB_LOST 3
`define ST_OWN_HIT 2
`define ST_GEN_CALL 1
`define ST_ACK_BIT 0

// Mode register fields
`define MODE_PRIMARY_FMT 0
`define MODE_SECOND_FMT 1
`define MODE_FORMATLESS 2
`define MODE_SERIAL 3

// Reset values and general call address
`define RST_BYTE 8'h00
`define RST_ADDR 7'h00
`define GEN_CALL_ADDR 7'h00

`endif

// [src/i2c_interrupt_status_flags.v]
// Operation
// - Transfer irq flag clears by read-1-write-0 or transfer unit data access.
// - Master: start seen after start request sets irq flag and tx empty.
// - Master with pause selected: pause before acknowledge sets irq flag.
// - Transfer end sets irq at ninth rise, or eighth fall with pause.
// - After arbitration loss, a received slave address sets irq flag.
// - Ack check on and ack received as 1 sets irq; in transmit it also sets ack bit.
// - Own or second address match sets hit flag, irq, until start/stop.
// - General call with primary format 0 sets flag, irq, until start/stop.
// - Slave stop detection sets irq with normal-end or early-end flag.
// - Serial/formatless: irq on end, start (serial only), formatless on, empty/full set.
// - Condition strobe reads 1, stores nothing, ignores written 1.
// - Slave: stop during a frame sets the early-end flag.
// - Slave: stop after a complete frame sets the normal-end flag.
// - End flags clear by read-1-write-0 or when irq flag clears.
// - Continuous flag sets irq too; outside slave set on empty/full.
// - Slave: continuous flag set on empty/full only while second hit.
// - Continuous flag clears by read-1-write-0 or when irq flag clears.
// - Slave receive, second format 0: first frame matching second address.
// - Second hit clears by read-1-write-0, on start, and in master mode.
// - Master transmit: internal SDA differs from pin at SCL rise, lost.
// - Arbitration lost clears on data access by direction or read-1-write-0.
// - SDA fall with SCL high is start, sets occupied; rise is stop.
// - Master transmit: internal SCL high at SCL fall sets arbitration lost.
`timescale 1ns/1ps
`include "i2c_status_defines.vh"

module i2c_interrupt_status_flags
(
	// Clock and reset
	input wire core_clk,
	input wire sys_rst,
	// Register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// Transfer unit access to the data register
	input wire dma_data_wr,
	input wire dma_data_rd,
	input wire [7:0] dma_wdata,
	// Bus pin levels
	input wire scl_pin,
	input wire sda_pin,
	// Shifter status
	input wire [7:0] rx_byte,
	input wire int_sda,
	input wire int_scl,
	input wire frame_active,
	input wire xfer_end,
	input wire pause_ins,
	input wire ack_valid,
	input wire ack_value,
	input wire addr_done,
	input wire [7:0] addr_byte,
	input wire tx_empty_set,
	input wire rx_full_set,
	// Shifter control
	output reg [7:0] tx_byte,
	output reg start_req,
	output reg stop_req,
	output reg iface_en,
	output reg master_sel,
	output reg direction_sel,
	output reg ack_check_en,
	output reg pause_sel,
	output reg ack_bit,
	output reg tx_data_empty,
	output reg rx_data_full,
	output reg transfer_irq_flag
);

	// ************************************************************
	// Pin synchronisers and bus conditions
	// ************************************************************
	reg scl_meta;
	reg sda_meta;
	reg scl_s;
	reg sda_s;
	reg scl_q;
	reg sda_q;
	wire scl_rise;
	wire scl_fall;
	wire start_det;
	wire stop_det;

	always @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			scl_meta <= 1'b1;
			sda_meta <= 1'b1;
			scl_s <= 1'b1;
			sda_s <= 1'b1;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_meta <= scl_pin;
			sda_meta <= sda_pin;
			scl_s <= scl_meta;
			sda_s <= sda_meta;
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_q;
	assign scl_fall = ~scl_s & scl_q;
	assign start_det = iface_en & scl_s & scl_q & sda_q & ~sda_s;
	assign stop_det = iface_en & scl_s & scl_q & ~sda_q & sda_s;

	// ************************************************************
	// Register storage
	// ************************************************************
	reg bus_occupied_flag;
	reg early_end_flag;
	reg normal_end_flag;
	reg continuous_xfer_flag;
	reg second_addr_hit;
	reg arb_lost_flag;
	reg own_addr_hit;
	reg general_call_flag;
	reg primary_format_sel;
	reg second_format_sel;
	reg formatless_sel;
	reg serial_sel;
	reg [6:0] own_addr;
	reg [6:0] second_addr;
	reg start_pending;
	reg first_frame;
	reg addressed;
	// Flags seen as 1 by a read; only those may be cleared by writing 0
	reg seen_irq;
	reg seen_early;
	reg seen_normal;
	reg seen_cont;
	reg seen_second;
	reg seen_arb;

	wire wr_ctrl = reg_wr & (reg_addr == `OFS_CTRL);
	wire wr_stat = reg_wr & (reg_addr == `OFS_STATUS);
	wire wr_mode = reg_wr & (reg_addr == `OFS_MODE);
	wire wr_own = reg_wr & (reg_addr == `OFS_OWN_ADDR);
	wire wr_second = reg_wr & (reg_addr == `OFS_SECOND_ADDR);
	wire wr_data = reg_wr & (reg_addr == `OFS_DATA);
	wire rd_ctrl = reg_rd & (reg_addr == `OFS_CTRL);
	wire rd_stat = reg_rd & (reg_addr == `OFS_STATUS);
	wire rd_data = reg_rd & (reg_addr == `OFS_DATA);

	wire i2c_fmt = ~formatless_sel & ~serial_sel;
	wire slave_i2c = i2c_fmt & ~master_sel;
	wire data_wr_any = wr_data | dma_data_wr;
	wire data_rd_any = rd_data | dma_data_rd;

	// ************************************************************
	// Event decode
	// ************************************************************
	wire empty_rise = tx_empty_set & ~tx_data_empty;
	wire full_rise = rx_full_set & ~rx_data_full;
	wire start_seen = start_det & start_pending & master_sel;
	wire buf_rise = empty_rise | full_rise | start_seen;
	wire end_evt = pause_sel ? pause_ins : xfer_end;
	wire end_counts = (master_sel & i2c_fmt) | (slave_i2c & addressed);
	wire is_gen_call = (addr_byte[7:1] == `GEN_CALL_ADDR);
	wire hit_own = addr_byte[7:1] == own_addr;
	wire hit_second = (addr_byte[7:1] == second_addr) & ~addr_byte[0] & ~second_format_sel;
	wire hit_gen = is_gen_call & ~primary_format_sel;
	wire addr_evt = addr_done & first_frame & slave_i2c;
	wire any_hit = addr_evt & (hit_own | hit_second | hit_gen);
	wire arb_mon = master_sel & direction_sel & i2c_fmt;
	wire arb_set = arb_mon & ((scl_rise & (int_sda != sda_s)) | (scl_fall & int_scl));
	wire fmtless_on = wr_mode & reg_wdata[`MODE_FORMATLESS] & ~formatless_sel;

	// Continuous-transfer setting depends on mode
	wire cont_set = (slave_i2c ? second_addr_hit : 1'b1) & (empty_rise | full_rise);

	// Every irq source gathered in one term
	wire irq_set = start_seen |
		(master_sel & i2c_fmt & pause_sel & pause_ins) |
		(end_evt & end_counts) |
		(addr_done & arb_lost_flag) |
		(ack_valid & ack_check_en & ack_value & i2c_fmt) |
		any_hit |
		(stop_det & slave_i2c) |
		(~i2c_fmt & (xfer_end | empty_rise | full_rise)) |
		(serial_sel & start_det) |
		fmtless_on |
		cont_set;

	// Clearing of the irq flag by software or the transfer unit
	wire irq_clr_cpu = wr_ctrl & seen_irq & ~reg_wdata[`CTRL_IRQ];
	wire irq_clr_dma = (dma_data_wr & tx_data_empty) | (dma_data_rd & rx_data_full);
	wire irq_falls = transfer_irq_flag & ~irq_set & (irq_clr_cpu | irq_clr_dma);

	// ************************************************************
	// Control register and condition requests
	// ************************************************************
	always @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			iface_en <= 1'b0;
			master_sel <= 1'b0;
			direction_sel <= 1'b0;
			ack_check_en <= 1'b0;
			pause_sel <= 1'b0;
			start_req <= 1'b0;
			stop_req <= 1'b0;
			start_pending <= 1'b0;
			bus_occupied_flag <= 1'b0;
		end
		else
		begin
			start_req <= 1'b0;
			stop_req <= 1'b0;
			if (wr_ctrl)
			begin
				iface_en <= reg_wdata[`CTRL_EN];
				master_sel <= reg_wdata[`CTRL_MASTER];
				direction_sel <= reg_wdata[`CTRL_DIR];
				ack_check_en <= reg_wdata[`CTRL_ACK_CHECK];
				pause_sel <= reg_wdata[`CTRL_PAUSE];
				// Strobe low issues a condition; a written 1 is dropped
				if (master_sel & iface_en & ~reg_wdata[`CTRL_COND_ISSUE])
				begin
					if (reg_wdata[`CTRL_BUS_OCC])
					begin
						start_req <= 1'b1;
						start_pending <= 1'b1;
					end
					else
					begin
						stop_req <= 1'b1;
					end
				end
			end
			else if (arb_set)
			begin
				// Losing the bus drops back to slave receive
				master_sel <= 1'b0;
				direction_sel <= 1'b0;
			end
			else if (addr_evt & any_hit & addr_byte[0])
			begin
				direction_sel <= 1'b1;
			end
			else if (fmtless_on)
			begin
				direction_sel <= direction_sel;
			end
			if (start_seen)
			begin
				start_pending <= 1'b0;
			end
			if (start_det)
			begin
				bus_occupied_flag <= 1'b1;
			end
			else if (stop_det | ~iface_en)
			begin
				bus_occupied_flag <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Mode, address and data registers
	// ************************************************************
	always @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			primary_format_sel <= 1'b0;
			second_format_sel <= 1'b0;
			formatless_sel <= 1'b0;
			serial_sel <= 1'b0;
			own_addr <= `RST_ADDR;
			second_addr <= `RST_ADDR;
			tx_byte <= `RST_BYTE;
		end
		else
		begin
			if (wr_mode)
			begin
				primary_format_sel <= reg_wdata[`MODE_PRIMARY_FMT];
				second_format_sel <= reg_wdata[`MODE_SECOND_FMT];
				formatless_sel <= reg_wdata[`MODE_FORMATLESS];
				serial_sel <= reg_wdata[`MODE_SERIAL];
			end
			if (wr_own)
			begin
				own_addr <= reg_wdata[7:1];
			end
			if (wr_second)
			begin
				second_addr <= reg_wdata[7:1];
			end
			if (dma_data_wr)
			begin
				tx_byte <= dma_wdata;
			end
			else if (wr_data)
			begin
				tx_byte <= reg_wdata;
			end
		end
	end

	// ************************************************************
	// Buffer flags and slave address tracking
	// ************************************************************
	always @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tx_data_empty <= 1'b0;
			rx_data_full <= 1'b0;
			first_frame <= 1'b0;
			addressed <= 1'b0;
		end
		else if (~iface_en)
		begin
			tx_data_empty <= 1'b0;
			rx_data_full <= 1'b0;
			first_frame <= 1'b0;
			addressed <= 1'b0;
		end
		else
		begin
			// A set in the same cycle as the access wins
			if (empty_rise | start_seen)
			begin
				tx_data_empty <= 1'b1;
			end
			else if (data_wr_any)
			begin
				tx_data_empty <= 1'b0;
			end
			if (full_rise)
			begin
				rx_data_full <= 1'b1;
			end
			else if (data_rd_any)
			begin
				rx_data_full <= 1'b0;
			end
			if (start_det)
			begin
				first_frame <= 1'b1;
			end
			else if (addr_done)
			begin
				first_frame <= 1'b0;
			end
			if (start_det | stop_det | master_sel)
			begin
				addressed <= 1'b0;
			end
			else if (any_hit)
			begin
				addressed <= 1'b1;
			end
		end
	end

	// ************************************************************
	// Status flags
	// ************************************************************
	always @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			transfer_irq_flag <= 1'b0;
			early_end_flag <= 1'b0;
			normal_end_flag <= 1'b0;
			continuous_xfer_flag <= 1'b0;
			second_addr_hit <= 1'b0;
			arb_lost_flag <= 1'b0;
			own_addr_hit <= 1'b0;
			general_call_flag <= 1'b0;
			ack_bit <= 1'b0;
		end
		else if (~iface_en)
		begin
			transfer_irq_flag <= 1'b0;
			early_end_flag <= 1'b0;
			normal_end_flag <= 1'b0;
			continuous_xfer_flag <= 1'b0;
			second_addr_hit <= 1'b0;
			arb_lost_flag <= 1'b0;
			own_addr_hit <= 1'b0;
			general_call_flag <= 1'b0;
			ack_bit <= ack_bit;
		end
		else
		begin
			if (irq_set)
			begin
				transfer_irq_flag <= 1'b1;
			end
			else if (irq_clr_cpu | irq_clr_dma)
			begin
				transfer_irq_flag <= 1'b0;
			end
			if (stop_det & slave_i2c & frame_active)
			begin
				early_end_flag <= 1'b1;
			end
			else if ((wr_stat & seen_early & ~reg_wdata[`ST_EARLY_END]) | irq_falls)
			begin
				early_end_flag <= 1'b0;
			end
			if (stop_det & slave_i2c & ~frame_active)
			begin
				normal_end_flag <= 1'b1;
			end
			else if ((wr_stat & seen_normal & ~reg_wdata[`ST_NORMAL_END]) | irq_falls)
			begin
				normal_end_flag <= 1'b0;
			end
			if (cont_set)
			begin
				continuous_xfer_flag <= 1'b1;
			end
			else if ((wr_stat & seen_cont & ~reg_wdata[`ST_CONT_XFER]) | irq_falls)
			begin
				continuous_xfer_flag <= 1'b0;
			end
			// Master mode holds the flag clear as a level
			if (master_sel | start_det)
			begin
				second_addr_hit <= 1'b0;
			end
			else if (addr_evt & hit_second)
			begin
				second_addr_hit <= 1'b1;
			end
			else if (wr_stat & seen_second & ~reg_wdata[`ST_SECOND_HIT])
			begin
				second_addr_hit <= 1'b0;
			end
			if (arb_set)
			begin
				arb_lost_flag <= 1'b1;
			end
			else if ((direction_sel & data_wr_any) | (~direction_sel & data_rd_any) |
				(wr_stat & seen_arb & ~reg_wdata[`ST_ARB_LOST]))
			begin
				arb_lost_flag <= 1'b0;
			end
			if (addr_evt)
			begin
				own_addr_hit <= hit_own | hit_second;
				general_call_flag <= hit_gen;
			end
			else if (start_det | stop_det)
			begin
				own_addr_hit <= 1'b0;
				general_call_flag <= 1'b0;
			end
			// Transmit latches the received ack; receive keeps the written value
			if (ack_valid & ack_check_en & direction_sel)
			begin
				ack_bit <= ack_value;
			end
			else if (wr_stat & ~direction_sel)
			begin
				ack_bit <= reg_wdata[`ST_ACK_BIT];
			end
		end
	end

	// ************************************************************
	// Read-as-one tracking
	// ************************************************************
	always @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			seen_irq <= 1'b0;
			seen_early <= 1'b0;
			seen_normal <= 1'b0;
			seen_cont <= 1'b0;
			seen_second <= 1'b0;
			seen_arb <= 1'b0;
		end
		else
		begin
			seen_irq <= rd_ctrl ? transfer_irq_flag : (seen_irq & transfer_irq_flag);
			seen_early <= rd_stat ? early_end_flag : (seen_early & early_end_flag);
			seen_normal <= rd_stat ? normal_end_flag : (seen_normal & normal_end_flag);
			seen_cont <= rd_stat ? continuous_xfer_flag : (seen_cont & continuous_xfer_flag);
			seen_second <= rd_stat ? second_addr_hit : (seen_second & second_addr_hit);
			seen_arb <= rd_stat ? arb_lost_flag : (seen_arb & arb_lost_flag);
		end
	end

	// ************************************************************
	// Read data
	// ************************************************************
	always @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			reg_rdata <= `RST_BYTE;
		end
		else if (reg_rd)
		begin
			if (reg_addr == `OFS_CTRL)
			begin
				reg_rdata <= {iface_en, master_sel, direction_sel, ack_check_en,
					bus_occupied_flag, transfer_irq_flag, 1'b1, pause_sel};
			end
			else if (reg_addr == `OFS_STATUS)
			begin
				reg_rdata <= {early_end_flag, normal_end_flag, continuous_xfer_flag,
					second_addr_hit, arb_lost_flag, own_addr_hit, general_call_flag, ack_bit};
			end
			else if (reg_addr == `OFS_MODE)
			begin
				reg_rdata <= {4'h0, serial_sel, formatless_sel, second_format_sel,
					primary_format_sel};
			end
			else if (reg_addr == `OFS_OWN_ADDR)
			begin
				reg_rdata <= {own_addr, 1'b0};
			end
			else if (reg_addr == `OFS_SECOND_ADDR)
			begin
				reg_rdata <= {second_addr, 1'b0};
			end
			else if (reg_addr == `OFS_DATA)
			begin
				reg_rdata <= rx_byte;
			end
			else
			begin
				reg_rdata <= `RST_BYTE;
			end
		end
		else
		begin
			reg_rdata <= `RST_BYTE;
		end
	end

endmodule // i2c_interrupt_status_flags

// [verif/i2c_status_flags_sva.sv]
`timescale 1ns/1ps
`include "i2c_status_defines.vh"

module i2c_status_flags_sva
(
	// Clock and reset
	input wire core_clk,
	input wire sys_rst,
	// Register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	// Shifter side
	input wire dma_data_wr,
	input wire xfer_end,
	input wire pause_ins,
	input wire ack_valid,
	input wire ack_value,
	input wire addr_done,
	input wire tx_empty_set,
	input wire rx_full_set,
	// Control outputs
	input wire start_req,
	input wire stop_req,
	input wire iface_en,
	input wire master_sel,
	input wire direction_sel,
	input wire ack_check_en,
	input wire pause_sel,
	input wire ack_bit,
	input wire tx_data_empty,
	input wire rx_data_full,
	input wire transfer_irq_flag
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	wire ctrl_wr = reg_wr && (reg_addr == `OFS_CTRL);
	wire cond_wr = ctrl_wr && reg_wdata[7] && reg_wdata[6] && !reg_wdata[1];
	wire master_on = iface_en && master_sel;
	wire any_set = xfer_end || pause_ins || ack_valid || addr_done || tx_empty_set || rx_full_set;

	// ************
	// Assertions
	// ************
	a_start_issue: assert property (cond_wr && master_on && reg_wdata[3] |=> start_req ##1 !start_req)
		else $error("start request not pulsed");
	a_stop_issue: assert property (cond_wr && master_on && !reg_wdata[3] |=> stop_req ##1 !stop_req)
		else $error("stop request not pulsed");
	a_strobe_reads_one: assert property (reg_rd && reg_addr == `OFS_CTRL |=> reg_rdata[1])
		else $error("condition strobe bit read as 0");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside read answer");
	a_end_irq: assert property (master_on && !pause_sel && xfer_end |=> transfer_irq_flag)
		else $error("transfer end did not raise irq");
	a_pause_irq: assert property (master_on && pause_sel && pause_ins |=> transfer_irq_flag)
		else $error("pause did not raise irq");
	a_ack_irq: assert property (master_on && direction_sel && ack_check_en && ack_valid && ack_value
		|=> transfer_irq_flag && ack_bit)
		else $error("ack of 1 not flagged");
	a_cont_irq: assert property (master_on && ((tx_empty_set && !tx_data_empty) ||
		(rx_full_set && !rx_data_full)) |=> transfer_irq_flag)
		else $error("empty or full did not raise irq");
	a_dma_clear: assert property (iface_en && dma_data_wr && tx_data_empty && !any_set
		|=> !transfer_irq_flag && !tx_data_empty)
		else $error("transfer unit write did not clear irq");
	a_off_clear: assert property (!iface_en && !$past(iface_en) |-> !transfer_irq_flag && !tx_data_empty)
		else $error("flags held while disabled");

	c_start: cover property (cond_wr && reg_wdata[3] ##1 start_req);
	c_dma: cover property (dma_data_wr && tx_data_empty);
	c_ack: cover property (ack_valid && ack_value && ack_check_en);
endmodule // i2c_status_flags_sva

bind i2c_interrupt_status_flags i2c_status_flags_sva u_sva
(
	.core_clk(core_clk),
	.sys_rst(sys_rst),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.dma_data_wr(dma_data_wr),
	.xfer_end(xfer_end),
	.pause_ins(pause_ins),
	.ack_valid(ack_valid),
	.ack_value(ack_value),
	.addr_done(addr_done),
	.tx_empty_set(tx_empty_set),
	.rx_full_set(rx_full_set),
	.start_req(start_req),
	.stop_req(stop_req),
	.iface_en(iface_en),
	.master_sel(master_sel),
	.direction_sel(direction_sel),
	.ack_check_en(ack_check_en),
	.pause_sel(pause_sel),
	.ack_bit(ack_bit),
	.tx_data_empty(tx_data_empty),
	.rx_data_full(rx_data_full),
	.transfer_irq_flag(transfer_irq_flag)
);

// [verif/i2c_bus_peer.sv]
`timescale 1ns/1ps

module i2c_bus_peer
(
	// Bus lines, pulled up when released
	output reg scl,
	output reg sda
);
	initial
	begin
		scl = 1'b1;
		sda = 1'b1;
	end

	// Offset keeps line edges clear of the core clock edge
	task send_start;
	begin
		#3;
		sda = 1'b1;
		#80 scl = 1'b1;
		#80 sda = 1'b0;
		#80 scl = 1'b0;
		#80;
	end
	endtask

	task send_stop;
	begin
		#3;
		sda = 1'b0;
		#80 scl = 1'b1;
		#80 sda = 1'b1;
		#80;
	end
	endtask

	// Data set while clock low, line released after the pulse
	task send_bit(input logic v);
	begin
		#3;
		sda = v;
		#80 scl = 1'b1;
		#80 scl = 1'b0;
		#80 sda = 1'b1;
	end
	endtask
endmodule // i2c_bus_peer

// [verif/tb.sv]
`timescale 1ns/1ps
`include "i2c_status_defines.vh"

module tb;
	// ************
	// Signals
	// ************
	localparam logic [7:0] ctl = `OFS_CTRL;
	localparam logic [7:0] sts = `OFS_STATUS;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] sh = 8'h00;
	logic [7:0] dat = 8'h00;
	logic int_sda = 1'b0;
	logic int_scl = 1'b0;
	logic frame_active = 1'b0;
	logic [63:0] r;
	wire [7:0] reg_rdata;
	wire scl_pin;
	wire sda_pin;
	wire master_sel;
	wire tx_data_empty;
	wire transfer_irq_flag;
	wire [7:0] tx_byte;
	integer n_errors = 0;
	integer n_checks = 0;
	integer i;
	// Row: ctrl, mode, pulses, data, ctrl exp, mask, status exp, mask
	logic [63:0] rows [0:12] = '{
		64'hc2_00_01_00_c6_ff_00_fe, 64'hc3_00_02_00_c7_ff_00_fe,
		64'hf2_00_04_01_f6_ff_01_01, 64'hc2_00_10_00_c6_ff_20_fe,
		64'hc2_00_20_00_c6_ff_20_fe, 64'h82_08_01_00_86_ff_00_00,
		64'h82_08_10_00_86_ff_20_20, 64'h82_00_10_00_00_00_00_20,
		64'h82_00_08_54_8e_ff_04_04, 64'h82_00_08_66_8e_ff_10_10,
		64'h82_00_08_00_8e_ff_02_02, 64'h82_01_08_00_00_00_00_02,
		64'h82_02_08_66_00_00_00_10};

	initial
	begin
		forever #10 core_clk = ~core_clk;
	end

	i2c_interrupt_status_flags u_i2c_interrupt_status_flags
	(
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.dma_data_wr(sh[6]),
		.dma_data_rd(sh[7]),
		.dma_wdata(dat),
		.scl_pin(scl_pin),
		.sda_pin(sda_pin),
		.rx_byte(8'h3c),
		.int_sda(int_sda),
		.int_scl(int_scl),
		.frame_active(frame_active),
		.xfer_end(sh[0]),
		.pause_ins(sh[1]),
		.ack_valid(sh[2]),
		.ack_value(dat[0]),
		.addr_done(sh[3]),
		.addr_byte(dat),
		.tx_empty_set(sh[4]),
		.rx_full_set(sh[5]),
		.tx_byte(tx_byte),
		.start_req(),
		.stop_req(),
		.iface_en(),
		.master_sel(master_sel),
		.direction_sel(),
		.ack_check_en(),
		.pause_sel(),
		.ack_bit(),
		.tx_data_empty(tx_data_empty),
		.rx_data_full(),
		.transfer_irq_flag(transfer_irq_flag)
	);

	i2c_bus_peer u_i2c_bus_peer
	(
		.scl(scl_pin),
		.sda(sda_pin)
	);

	// ************
	// Tasks
	// ************
	task check(input string name, input logic [7:0] exp, input logic [7:0] got);
	begin
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
	begin
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	end
	endtask

	// Answer stands only in the cycle after the strobe
	task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
	begin
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		check($sformatf("reg %h", a), e & m, reg_rdata & m);
	end
	endtask

	task pulse(input logic [7:0] m);
	begin
		@(posedge core_clk);
		sh <= m;
		@(posedge core_clk);
		sh <= 8'h00;
	end
	endtask

	task finish_test;
	begin
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask

	initial
	begin
		#100000;
		n_errors++;
		finish_test();
	end

	// ************
	// Sequence
	// ************
	initial
	begin
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(sts, 8'h00, 8'hff);
		rd(ctl, 8'h02, 8'hff);
		wr(8'h3f, 8'hff);
		rd(8'h3f, 8'h00, 8'hff);
		wr(`OFS_OWN_ADDR, 8'h54);
		wr(`OFS_SECOND_ADDR, 8'h66);
		for (i = 0; i < 13; i++)
		begin
			r = rows[i];
			wr(ctl, r[63:56]);
			wr(`OFS_MODE, r[55:48]);
			dat <= r[39:32];
			// Address frames only count after a start on the bus
			if (r[43])
			begin
				u_i2c_bus_peer.send_start();
			end
			pulse(r[47:40]);
			rd(ctl, r[31:24], r[23:16]);
			rd(sts, r[15:8], r[7:0]);
			wr(ctl, 8'h02);
		end
		wr(`OFS_MODE, 8'h00);
		// Clearing needs a prior read of 1
		wr(ctl, 8'hc2);
		pulse(8'h10);
		wr(ctl, 8'hc2);
		rd(ctl, 8'hc6, 8'hff);
		rd(sts, 8'h20, 8'h20);
		wr(sts, 8'h20);
		rd(sts, 8'h20, 8'h20);
		wr(ctl, 8'hc2);
		rd(ctl, 8'hc2, 8'hff);
		rd(sts, 8'h00, 8'h20);
		pulse(8'h40);
		pulse(8'h10);
		rd(ctl, 8'hc6, 8'hff);
		pulse(8'h40);
		rd(ctl, 8'hc2, 8'hff);
		check("tx empty", 8'h00, {7'h00, tx_data_empty});
		check("tx byte", 8'h66, tx_byte);
		// Arbitration lost on data, then address while lost
		wr(ctl, 8'h02);
		wr(ctl, 8'he2);
		int_sda <= 1'b1;
		u_i2c_bus_peer.send_start();
		u_i2c_bus_peer.send_bit(1'b0);
		rd(sts, 8'h08, 8'h08);
		check("master", 8'h00, {7'h00, master_sel});
		rd(ctl, 8'h00, 8'h00);
		wr(ctl, 8'h82);
		dat <= 8'h20;
		pulse(8'h08);
		rd(ctl, 8'h04, 8'h04);
		rd(sts, 8'h08, 8'h08);
		rd(`OFS_DATA, 8'h3c, 8'hff);
		rd(sts, 8'h00, 8'h08);
		u_i2c_bus_peer.send_stop();
		wr(ctl, 8'h02);
		wr(ctl, 8'he2);
		int_sda <= 1'b0;
		int_scl <= 1'b1;
		u_i2c_bus_peer.send_start();
		u_i2c_bus_peer.send_bit(1'b0);
		rd(sts, 8'h08, 8'h08);
		int_scl <= 1'b0;
		u_i2c_bus_peer.send_stop();
		// Start and stop requested by software
		wr(ctl, 8'h02);
		wr(ctl, 8'he2);
		wr(ctl, 8'he8);
		u_i2c_bus_peer.send_start();
		rd(ctl, 8'hee, 8'hff);
		check("tx empty", 8'h01, {7'h00, tx_data_empty});
		wr(ctl, 8'he0);
		u_i2c_bus_peer.send_stop();
		rd(ctl, 8'h00, 8'h08);
		// Slave stop inside and after a frame
		wr(ctl, 8'h02);
		wr(ctl, 8'h82);
		for (i = 0; i < 2; i++)
		begin
			frame_active <= (i == 0);
			u_i2c_bus_peer.send_start();
			dat <= 8'h54;
			pulse(8'h08);
			rd(ctl, 8'h04, 8'h04);
			wr(ctl, 8'h82);
			u_i2c_bus_peer.send_stop();
			rd(ctl, 8'h04, 8'h04);
			rd(sts, i ? 8'h40 : 8'h80, 8'hc0);
			wr(ctl, 8'h82);
			rd(sts, 8'h00, 8'hc0);
		end
		// Second address, continuous flag, second hit cleared by start
		u_i2c_bus_peer.send_start();
		dat <= 8'h66;
		pulse(8'h08);
		pulse(8'h10);
		rd(sts, 8'h30, 8'h30);
		u_i2c_bus_peer.send_start();
		rd(sts, 8'h00, 8'h10);
		u_i2c_bus_peer.send_stop();
		wr(ctl, 8'h02);
		wr(ctl, 8'h82);
		wr(`OFS_MODE, 8'h04);
		rd(ctl, 8'h04, 8'h04);
		// Mid-run reset returns every register to idle
		@(posedge core_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(ctl, 8'h02, 8'hff);
		rd(`OFS_MODE, 8'h00, 8'hff);
		rd(sts, 8'h00, 8'hff);
		finish_test();
	end
endmodule // tb
